/* File: include/pp_decode_map.svh */
// register offsets, field positions and reset values of the parallel port register bank
`ifndef PP_DECODE_MAP_SVH
`define PP_DECODE_MAP_SVH
// apb map: paddr[15] selects configuration space, word index in paddr[12:2]
`define CFG_SPACE_BIT   15
`define IDX_LSB         2
`define IDX_W           11
// configuration indexes
`define CFG_ACTIVATE    11'h030
`define CFG_BASE_HIGH   11'h060
`define CFG_BASE_LOW    11'h061
`define CFG_IRQ_NUM     11'h070
`define CFG_IRQ_TYPE    11'h071
`define CFG_DMA_SEL     11'h074
`define CFG_DMA_REPORT  11'h075
`define CFG_PORT_SETUP  11'h0F0
// runtime first-level offsets
`define RT_DATA         11'h000
`define RT_STATUS       11'h001
`define RT_CONTROL      11'h002
`define RT_EPP_ADDR     11'h003
`define RT_EPP_BYTE0    11'h004
`define RT_EPP_BYTE3    11'h007
`define RT_FIFO         11'h400
`define RT_CAP_B        11'h401
`define RT_MODE_CTL     11'h402
`define RT_EXT_INDEX    11'h403
`define RT_EXT_WINDOW   11'h404
`define RT_EXT_AUX      11'h405
// second-level offsets
`define EXT_CTL0        8'h00
`define EXT_CTL2        8'h02
`define EXT_CTL4        8'h04
`define EXT_SETUP0      8'h05
// reset values
`define RST_ACTIVATE    8'h00
`define RST_BASE_HIGH   8'h02
`define RST_BASE_LOW    8'h78
`define RST_IRQ_NUM     8'h07
`define RST_IRQ_TYPE    8'h02
`define RST_DMA_SEL     8'h04
`define VAL_DMA_REPORT  8'h04
`define RST_PORT_SETUP  8'hF2
`define RST_MODE_CTL    8'h00
`define RD_UNMAPPED     8'h00
// fields
`define SETUP_EXT_EN    4
`define SETUP_MODE_HI   7
`define SETUP_MODE_LO   5
`define MODE_HI         7
`define MODE_LO         5
`define BASE_HIGH_WMASK 8'h07
`define BASE_LOW_WMASK  8'hFC
`define IRQ_TYPE_WMASK  8'h02
`define SETUP_ECP_EPP   3'h7
`define MODE_EPP        3'h4
`define MODE_NONE       3'h5
`endif

/* File: include/pp_decode_pkg.sv */
// types shared by the parallel port register bank
package pp_decode_pkg;
    typedef enum {
        REG_NONE, REG_OUTPUT_LATCH, REG_ADDR_FIFO, REG_EPP_DATA, REG_LINE_STATUS, REG_EPP_STATUS,
        REG_LINE_CONTROL, REG_EPP_CONTROL, REG_EPP_LOCATION, REG_EPP_BYTE, REG_PP_FIFO, REG_ECP_FIFO,
        REG_TEST_FIFO, REG_CAP_A, REG_CAP_B, REG_MODE_CTL, REG_EXT_INDEX, REG_EXT_WINDOW, REG_EXT_AUX
    } rt_reg_e;
    typedef logic [7:0] byte_t;
endpackage

/* File: rtl/pp_register_decode.sv */
// apb register bank of the parallel port: configuration set and mode-dependent runtime decode
//
// Summary of operation
// - mode comes from mode control register when setup bit 7 is set, else from setup bits 6-5
// - mode selects runtime decode and base alignment
// - 21 runtime registers share 14 offsets
// - offsets 403h-405h serve extended mode only
// - four second-level registers reached by index
// - extended registers need setup bit 4
// - extended accesses ignored while bit 4 clear
// - base high bits 7-3 read zero
// - base low bits 1-0 read zero
// - base bytes reset to 02h and 78h
// - irq type: only bit 1 writable
// - irq type bit 0 shows level in ecp+epp setup
// - irq number resets 07h, type 02h
// - dma select and report reset 04h
// - activate resets 00h, gated by global bit
// - port setup register resets to F2h
// - compatibility, bidirectional, fifo, epp, ecp modes
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "pp_decode_map.svh"

module pp_register_decode
    import pp_decode_pkg::*;
#(
    parameter int    ADDR_W = 16,
    parameter byte_t CAP_A  = 8'h10,  // arbitrary capability value
    parameter byte_t CAP_B  = 8'h00   // arbitrary capability value
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              global_enable,
    input  wire logic [7:0]        line_status_in,
    input  wire logic [7:0]        fifo_rdata,
    output logic      [7:0]        fifo_wdata,
    output logic                   fifo_push,
    output logic                   fifo_pop,
    output logic      [7:0]        output_latch,
    output logic      [7:0]        line_control,
    output logic      [15:0]       io_base,
    output logic                   io_align8,
    output logic      [2:0]        port_mode,
    output logic                   port_active
);
    if (ADDR_W < 16) begin : g_chk
        $error("ADDR_W below 16 cannot hold the register map");
    end

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic rt_reg_e rt_decode(input logic [10:0] off, input logic [2:0] m, input logic ext_ok);
        rt_decode = REG_NONE;
        case (off)
            `RT_DATA:       rt_decode = (m <= 3'd1) ? REG_OUTPUT_LATCH : (m == 3'd3) ? REG_ADDR_FIFO :
                                        (m == `MODE_EPP) ? REG_EPP_DATA : REG_NONE;
            `RT_STATUS:     rt_decode = (m <= 3'd3) ? REG_LINE_STATUS : (m == `MODE_EPP) ? REG_EPP_STATUS : REG_NONE;
            `RT_CONTROL:    rt_decode = (m <= 3'd3) ? REG_LINE_CONTROL : (m == `MODE_EPP) ? REG_EPP_CONTROL : REG_NONE;
            `RT_EPP_ADDR:   rt_decode = (m == `MODE_EPP) ? REG_EPP_LOCATION : REG_NONE;
            `RT_FIFO:       rt_decode = (m == 3'd2) ? REG_PP_FIFO : (m == 3'd3) ? REG_ECP_FIFO :
                                        (m == 3'd6) ? REG_TEST_FIFO : (m == 3'd7) ? REG_CAP_A : REG_NONE;
            `RT_CAP_B:      rt_decode = (m == 3'd7) ? REG_CAP_B : REG_NONE;
            `RT_MODE_CTL:   rt_decode = REG_MODE_CTL;
            `RT_EXT_INDEX:  rt_decode = ext_ok ? REG_EXT_INDEX : REG_NONE;
            `RT_EXT_WINDOW: rt_decode = ext_ok ? REG_EXT_WINDOW : REG_NONE;
            `RT_EXT_AUX:    rt_decode = ext_ok ? REG_EXT_AUX : REG_NONE;
            default: begin
                if (off >= `RT_EPP_BYTE0 && off <= `RT_EPP_BYTE3 && m == `MODE_EPP) begin
                    rt_decode = REG_EPP_BYTE;
                end
            end
        endcase
    endfunction

    // second-level slot: {valid, slot}
    function automatic logic [2:0] ext_slot(input byte_t idx);
        case (idx)
            `EXT_CTL0:   ext_slot = 3'h4;
            `EXT_CTL2:   ext_slot = 3'h5;
            `EXT_CTL4:   ext_slot = 3'h6;
            `EXT_SETUP0: ext_slot = 3'h7;
            default:     ext_slot = 3'h0;
        endcase
    endfunction

    // ****************************************
    // state and decode
    // ****************************************
    byte_t       activate_q, base_hi_q, base_lo_q, irq_num_q, irq_type_q, dma_sel_q, setup_q;
    byte_t       mode_ctl_q, index_q, aux_q, latch_q, epp_data_q, control_q, location_q;
    byte_t       epp_byte_q [4];
    byte_t       ext_q [4];
    logic        first_q;
    logic [2:0]  mode_w;
    logic        ext_ok_w, cfg_w, wr_en, rd_setup;
    logic [10:0] idx_w;
    rt_reg_e     sel_w;
    logic [2:0]  slot_w;
    byte_t       wbyte, rd_d;

    // compatibility, bidirectional and epp setups force the mode, ecp setups take it from software
    always_comb begin
        if (setup_q[`SETUP_MODE_HI]) begin
            mode_w = mode_ctl_q[`MODE_HI:`MODE_LO];
            if (mode_w == `MODE_EPP && setup_q[`SETUP_MODE_HI:`SETUP_MODE_LO] != `SETUP_ECP_EPP) begin
                mode_w = `MODE_NONE;
            end
        end else begin
            case (setup_q[6:5])
                2'b00:   mode_w = 3'd0;
                2'b01:   mode_w = 3'd1;
                default: mode_w = `MODE_EPP;
            endcase
        end
    end

    assign ext_ok_w = setup_q[`SETUP_EXT_EN] && setup_q[`SETUP_MODE_HI] && mode_w <= 3'd3;
    assign cfg_w    = paddr[`CFG_SPACE_BIT];
    assign idx_w    = paddr[`IDX_LSB +: `IDX_W];
    assign sel_w    = cfg_w ? REG_NONE : rt_decode(idx_w, mode_w, ext_ok_w);
    assign slot_w   = ext_slot(index_q);
    assign wr_en    = psel && penable && pwrite && pready;
    assign rd_setup = psel && !penable && !pwrite;
    assign wbyte    = pstrb[0] ? pwdata[7:0] : rd_d;

    // ****************************************
    // read multiplexer
    // ****************************************
    always_comb begin
        rd_d = `RD_UNMAPPED;
        if (cfg_w) begin
            case (idx_w)
                `CFG_ACTIVATE:   rd_d = activate_q;
                `CFG_BASE_HIGH:  rd_d = base_hi_q;
                `CFG_BASE_LOW:   rd_d = base_lo_q;
                `CFG_IRQ_NUM:    rd_d = irq_num_q;
                `CFG_IRQ_TYPE:   rd_d = {irq_type_q[7:1], setup_q[7:5] == `SETUP_ECP_EPP};
                `CFG_DMA_SEL:    rd_d = dma_sel_q;
                `CFG_DMA_REPORT: rd_d = `VAL_DMA_REPORT;
                `CFG_PORT_SETUP: rd_d = setup_q;
                default:         rd_d = `RD_UNMAPPED;
            endcase
        end else begin
            case (sel_w)
                REG_OUTPUT_LATCH:                  rd_d = latch_q;
                REG_EPP_DATA:                      rd_d = epp_data_q;
                REG_LINE_STATUS, REG_EPP_STATUS:   rd_d = line_status_in;
                REG_LINE_CONTROL, REG_EPP_CONTROL: rd_d = control_q;
                REG_EPP_LOCATION:                  rd_d = location_q;
                REG_EPP_BYTE:                      rd_d = epp_byte_q[idx_w[1:0]];
                REG_ECP_FIFO, REG_TEST_FIFO:       rd_d = fifo_rdata;
                REG_CAP_A:                         rd_d = CAP_A;
                REG_CAP_B:                         rd_d = CAP_B;
                REG_MODE_CTL:                      rd_d = mode_ctl_q;
                REG_EXT_INDEX:                     rd_d = index_q;
                REG_EXT_WINDOW:                    rd_d = slot_w[2] ? ext_q[slot_w[1:0]] : `RD_UNMAPPED;
                REG_EXT_AUX:                       rd_d = aux_q;
                default:                           rd_d = `RD_UNMAPPED;
            endcase
        end
    end

    // ****************************************
    // apb answer: no wait state, read data is registered from the setup cycle so that it comes from a flop
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (rd_setup) begin
                prdata <= {24'h00_0000, rd_d};
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            activate_q <= `RST_ACTIVATE;
            base_hi_q  <= `RST_BASE_HIGH;
            base_lo_q  <= `RST_BASE_LOW;
            irq_num_q  <= `RST_IRQ_NUM;
            irq_type_q <= `RST_IRQ_TYPE;
            dma_sel_q  <= `RST_DMA_SEL;
            setup_q    <= `RST_PORT_SETUP;
        end else if (wr_en && cfg_w) begin
            case (idx_w)
                `CFG_ACTIVATE:   activate_q <= wbyte;
                `CFG_BASE_HIGH:  base_hi_q  <= wbyte & `BASE_HIGH_WMASK;
                `CFG_BASE_LOW:   base_lo_q  <= wbyte & `BASE_LOW_WMASK;
                `CFG_IRQ_NUM:    irq_num_q  <= wbyte;
                `CFG_IRQ_TYPE:   irq_type_q <= wbyte & `IRQ_TYPE_WMASK;
                `CFG_DMA_SEL:    dma_sel_q  <= wbyte;
                `CFG_PORT_SETUP: setup_q    <= wbyte;
                default:         ;
            endcase
        end
    end

    // ****************************************
    // runtime registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctl_q <= `RST_MODE_CTL;
            index_q    <= 8'h00;
            aux_q      <= 8'h00;
            latch_q    <= 8'h00;
            epp_data_q <= 8'h00;
            control_q  <= 8'h00;
            location_q <= 8'h00;
            epp_byte_q <= '{default: 8'h00};
            ext_q      <= '{default: 8'h00};
        end else if (wr_en && !cfg_w) begin
            case (sel_w)
                REG_OUTPUT_LATCH:                  latch_q    <= wbyte;
                REG_EPP_DATA:                      epp_data_q <= wbyte;
                REG_LINE_CONTROL, REG_EPP_CONTROL: control_q  <= wbyte;
                REG_EPP_LOCATION:                  location_q <= wbyte;
                REG_EPP_BYTE:                      epp_byte_q[idx_w[1:0]] <= wbyte;
                REG_MODE_CTL:                      mode_ctl_q <= wbyte;
                REG_EXT_INDEX:                     index_q    <= wbyte;
                REG_EXT_AUX:                       aux_q      <= wbyte;
                REG_EXT_WINDOW: begin
                    if (slot_w[2]) begin
                        ext_q[slot_w[1:0]] <= wbyte;
                    end
                end
                default: ;
            endcase
        end
    end

    // ****************************************
    // fifo strobes toward the data path
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_push  <= 1'b0;
            fifo_pop   <= 1'b0;
            fifo_wdata <= 8'h00;
        end else begin
            fifo_push <= wr_en && !cfg_w &&
                         (sel_w inside {REG_ADDR_FIFO, REG_PP_FIFO, REG_ECP_FIFO, REG_TEST_FIFO});
            fifo_pop  <= psel && penable && pready && !pwrite && !cfg_w &&
                         (sel_w inside {REG_ECP_FIFO, REG_TEST_FIFO});
            if (wr_en) begin
                fifo_wdata <= wbyte;
            end
        end
    end

    // ****************************************
    // port-facing state
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_latch <= 8'h00;
            line_control <= 8'h00;
            io_base      <= 16'h0000;
            io_align8    <= 1'b0;
            port_mode    <= 3'd0;
            port_active  <= 1'b0;
            first_q      <= 1'b1;
        end else begin
            output_latch <= (mode_w == `MODE_EPP) ? epp_data_q : latch_q;
            line_control <= control_q;
            io_base      <= {base_hi_q, base_lo_q};
            // epp and the extended registers span eight bytes, so bit 2 leaves the match
            io_align8    <= mode_w == `MODE_EPP || ext_ok_w;
            port_mode    <= mode_w;
            port_active  <= activate_q[0] && global_enable;
            first_q      <= 1'b0;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mode_sel;
        wr_en && !cfg_w && idx_w == `RT_MODE_CTL && setup_q[7:5] == `SETUP_ECP_EPP && pwdata[7:5] != `MODE_EPP
        && pstrb[0] ##1 1 |=> port_mode == $past(pwdata[7:5], 2);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("mode does not follow mode control");

    property p_align;
        (mode_w == `MODE_EPP) |=> io_align8;
    endproperty
    a_align: assert property (p_align) else $error("epp mode without eight-byte alignment");

    property p_ext_ignored;
        wr_en && !cfg_w && idx_w == `RT_EXT_INDEX && !setup_q[`SETUP_EXT_EN] |=> $stable(index_q);
    endproperty
    a_ext_ignored: assert property (p_ext_ignored) else $error("index written while disabled");

    property p_ext_read_zero;
        rd_setup && !cfg_w && idx_w == `RT_EXT_AUX && !ext_ok_w |=> prdata == 32'h0 && pready;
    endproperty
    a_ext_read_zero: assert property (p_ext_read_zero) else $error("aux status visible while disabled");

    property p_window;
        wr_en && !cfg_w && idx_w == `RT_EXT_WINDOW && ext_ok_w && index_q == `EXT_CTL2 && pstrb[0]
        |=> ext_q[1] == $past(pwdata[7:0]);
    endproperty
    a_window: assert property (p_window) else $error("second-level write lost");

    property p_base_high;
        wr_en && cfg_w && idx_w == `CFG_BASE_HIGH && pstrb[0] |=> base_hi_q == {5'h00, $past(pwdata[2:0])};
    endproperty
    a_base_high: assert property (p_base_high) else $error("base high read-only bits changed");

    property p_base_low;
        wr_en && cfg_w && idx_w == `CFG_BASE_LOW |=> base_lo_q[1:0] == 2'b00;
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low alignment bits set");

    property p_reset_vals;
        first_q |-> base_hi_q == 8'h02 && base_lo_q == 8'h78 && irq_num_q == 8'h07 && irq_type_q == 8'h02
                    && dma_sel_q == 8'h04 && activate_q == 8'h00 && setup_q == 8'hF2;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong reset values");

    property p_irq_type;
        rd_setup && cfg_w && idx_w == `CFG_IRQ_TYPE
        |=> prdata[7:2] == 6'h00 && prdata[0] == ($past(setup_q[7:5]) == 3'h7);
    endproperty
    a_irq_type: assert property (p_irq_type) else $error("interrupt type readback wrong");

    property p_unmapped;
        rd_setup && !cfg_w && sel_w == REG_NONE |=> prdata == 32'h0 ##1 !fifo_pop;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not fixed");

    c_epp_byte:  cover property (wr_en && sel_w == REG_EPP_BYTE);
    c_ext_write: cover property (wr_en && sel_w == REG_EXT_WINDOW && slot_w[2]);
    c_fifo_push: cover property (fifo_push);
    c_cap_read:  cover property (rd_setup && sel_w == REG_CAP_B);

endmodule // pp_register_decode

/* File: bench/parallel_port_register_decode_tb_top.sv */
// self-checking testbench of the parallel port register bank
`timescale 1ns/1ps
`include "pp_decode_map.svh"

module parallel_port_register_decode_tb_top import pp_decode_pkg::*;;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        global_enable;
    logic [7:0]  line_status_in;
    logic [7:0]  fifo_rdata;
    logic [7:0]  fifo_wdata;
    logic        fifo_push;
    logic        fifo_pop;
    logic [7:0]  output_latch;
    logic [7:0]  line_control;
    logic [15:0] io_base;
    logic        io_align8;
    logic [2:0]  port_mode;
    logic        port_active;
    int          mismatches = 0;
    int          checks     = 0;
    int          pushes     = 0;
    int          pops       = 0;

    pp_register_decode #(.ADDR_W(16)) pp_register_decode_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_enable(global_enable), .line_status_in(line_status_in), .fifo_rdata(fifo_rdata),
        .fifo_wdata(fifo_wdata), .fifo_push(fifo_push), .fifo_pop(fifo_pop), .output_latch(output_latch),
        .line_control(line_control), .io_base(io_base), .io_align8(io_align8), .port_mode(port_mode),
        .port_active(port_active)
    );

    // ****************************************
    // clock, strobe counters and bus helpers
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (fifo_push === 1'b1) pushes++;
        if (fifo_pop === 1'b1) pops++;
    end

    function automatic logic [15:0] cfg(input logic [10:0] idx);
        return {1'b1, 2'b00, idx, 2'b00};
    endfunction

    function automatic logic [15:0] rt(input logic [10:0] off);
        return {3'b000, off, 2'b00};
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // the master assumes no fixed latency: it holds the request until pready is seen, and fails after 20 cycles without it
    task automatic apb(input logic wr, input logic [15:0] a, input byte_t d, output byte_t q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            $display("Error at %0t: no ready", $time);
            report_and_stop;
        end else begin
            q = prdata[7:0];
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [15:0] a, input byte_t d);
        byte_t q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [15:0] a, input byte_t exp);
        byte_t q;
        apb(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, exp});
        chk({15'h0000, pslverr}, 16'h0000);
    endtask

    // outputs follow register state one cycle late
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        settle;
        chk(io_base, 16'h0278);
        chk({13'h0000, port_mode}, 16'h0000);
        chk({15'h0000, port_active}, 16'h0000);
        rd(cfg(`CFG_ACTIVATE), 8'h00);
        rd(cfg(`CFG_BASE_HIGH), 8'h02);
        rd(cfg(`CFG_BASE_LOW), 8'h78);
        rd(cfg(`CFG_IRQ_NUM), 8'h07);
        rd(cfg(`CFG_IRQ_TYPE), 8'h03);
        rd(cfg(`CFG_DMA_SEL), 8'h04);
        rd(cfg(`CFG_DMA_REPORT), 8'h04);
        rd(cfg(`CFG_PORT_SETUP), 8'hF2);
        $display("test reset values done");
    endtask

    task automatic t_config;
        wr(cfg(`CFG_BASE_HIGH), 8'hFF);
        rd(cfg(`CFG_BASE_HIGH), 8'h07);
        wr(cfg(`CFG_BASE_LOW), 8'hFF);
        rd(cfg(`CFG_BASE_LOW), 8'hFC);
        settle;
        chk(io_base, 16'h07FC);
        wr(cfg(`CFG_BASE_HIGH), 8'h02);
        wr(cfg(`CFG_BASE_LOW), 8'h78);
        wr(cfg(`CFG_IRQ_TYPE), 8'h00);
        rd(cfg(`CFG_IRQ_TYPE), 8'h01);
        wr(cfg(`CFG_IRQ_TYPE), 8'hFF);
        rd(cfg(`CFG_IRQ_TYPE), 8'h03);
        wr(cfg(`CFG_DMA_REPORT), 8'h00);
        rd(cfg(`CFG_DMA_REPORT), 8'h04);
        wr(cfg(`CFG_DMA_SEL), 8'h03);
        rd(cfg(`CFG_DMA_SEL), 8'h03);
        @(posedge pclk) pstrb <= 4'h0;
        wr(cfg(`CFG_DMA_SEL), 8'hEE);
        @(posedge pclk) pstrb <= 4'hF;
        rd(cfg(`CFG_DMA_SEL), 8'h03);
        rd(cfg(11'h022), 8'h00);
        wr(cfg(`CFG_ACTIVATE), 8'h01);
        settle;
        chk({15'h0000, port_active}, 16'h0001);
        @(posedge pclk) global_enable <= 1'b0;
        settle;
        chk({15'h0000, port_active}, 16'h0000);
        @(posedge pclk) global_enable <= 1'b1;
        $display("test configuration set done");
    endtask

    task automatic t_setup_modes;
        wr(cfg(`CFG_PORT_SETUP), 8'h12);
        rd(cfg(`CFG_PORT_SETUP), 8'h12);
        rd(cfg(`CFG_IRQ_TYPE), 8'h02);
        wr(cfg(`CFG_PORT_SETUP), 8'h32);
        settle;
        chk({13'h0000, port_mode}, 16'h0001);
        wr(cfg(`CFG_PORT_SETUP), 8'h52);
        settle;
        chk({13'h0000, port_mode}, 16'h0004);
        chk({15'h0000, io_align8}, 16'h0001);
        wr(rt(`RT_DATA), 8'h96);
        wr(rt(`RT_EPP_ADDR), 8'h44);
        settle;
        chk({8'h00, output_latch}, 16'h0096);
        rd(rt(`RT_EPP_ADDR), 8'h44);
        rd(rt(`RT_STATUS), 8'hA5);
        rd(rt(`RT_EXT_INDEX), 8'h00);
        wr(cfg(`CFG_PORT_SETUP), 8'hF2);
        $display("test setup modes done");
    endtask

    task automatic t_ext;
        wr(rt(`RT_EXT_INDEX), 8'h02);
        wr(rt(`RT_EXT_WINDOW), 8'h5A);
        wr(rt(`RT_EXT_INDEX), 8'h05);
        wr(rt(`RT_EXT_WINDOW), 8'hC3);
        wr(rt(`RT_EXT_INDEX), 8'h02);
        rd(rt(`RT_EXT_WINDOW), 8'h5A);
        rd(rt(`RT_EXT_INDEX), 8'h02);
        wr(rt(`RT_EXT_INDEX), 8'h01);
        wr(rt(`RT_EXT_WINDOW), 8'h77);
        rd(rt(`RT_EXT_WINDOW), 8'h00);
        wr(cfg(`CFG_PORT_SETUP), 8'hE2);
        rd(rt(`RT_EXT_INDEX), 8'h00);
        rd(rt(`RT_EXT_AUX), 8'h00);
        wr(rt(`RT_EXT_INDEX), 8'h05);
        settle;
        chk({15'h0000, io_align8}, 16'h0000);
        wr(cfg(`CFG_PORT_SETUP), 8'hF2);
        rd(rt(`RT_EXT_INDEX), 8'h01);
        wr(rt(`RT_EXT_INDEX), 8'h05);
        rd(rt(`RT_EXT_WINDOW), 8'hC3);
        $display("test extended registers done");
    endtask

    task automatic t_mode_control;
        int    p0;
        int    q0;
        byte_t exp;
        logic  push;
        logic  pop;
        for (int m = 0; m < 8; m++) begin
            exp  = (m == 3 || m == 6) ? 8'h3C : (m == 7) ? 8'h10 : 8'h00;
            push = (m == 2 || m == 3 || m == 6);
            pop  = (m == 3 || m == 6);
            wr(rt(`RT_MODE_CTL), {m[2:0], 5'h00});
            settle;
            chk(port_mode, {13'h0000, m[2:0]});
            rd(rt(`RT_MODE_CTL), {m[2:0], 5'h00});
            rd(rt(`RT_EXT_INDEX), (m < 4) ? 8'h05 : 8'h00);
            p0 = pushes;
            q0 = pops;
            wr(rt(`RT_FIFO), 8'h60 | 8'(m));
            rd(rt(`RT_FIFO), exp);
            settle;
            chk(16'(pushes - p0), {15'h0000, push});
            chk(16'(pops - q0), {15'h0000, pop});
            if (push) chk({8'h00, fifo_wdata}, 16'h0060 | 16'(m));
        end
        p0 = pushes;
        wr(rt(`RT_MODE_CTL), 8'h60);
        wr(rt(`RT_DATA), 8'h21);
        settle;
        chk(16'(pushes - p0), 16'h0001);
        wr(rt(`RT_MODE_CTL), 8'h00);
        wr(rt(`RT_DATA), 8'h5C);
        wr(rt(`RT_CONTROL), 8'h0E);
        settle;
        chk({8'h00, output_latch}, 16'h005C);
        chk({8'h00, line_control}, 16'h000E);
        rd(rt(`RT_DATA), 8'h5C);
        rd(rt(`RT_EPP_BYTE3), 8'h00);
        $display("test mode control done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000; pwdata = 32'h00000000;
        pstrb = 4'hF; presetn = 1'b0; global_enable = 1'b1; line_status_in = 8'hA5; fifo_rdata = 8'h3C;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_config;
        t_setup_modes;
        t_ext;
        t_mode_control;
        report_and_stop;
    end
endmodule // parallel_port_register_decode_tb_top
